// ==== pkg/psc_pkg.sv ====
// shared constants and types for the press stroke cycle sequencer
package psc_pkg;
    // stroke states, gray coded along the usual path except the two-bit step from PSC_UP back to PSC_TOP
    typedef enum logic [2:0] {
        PSC_TOP = 3'h0,
        PSC_DOWN = 3'h1,
        PSC_MUTE = 3'h3,
        PSC_MUTE8 = 3'h2,
        PSC_PAST6 = 3'h6,
        PSC_BOTTOM = 3'h7,
        PSC_UP = 3'h5
    } psc_state_t;

    // field mode encodings, {mode2, mode1}
    localparam logic [1:0] PSC_MODE_STANDARD = 2'h0;
    localparam logic [1:0] PSC_MODE_BOX = 2'h2;

    // controller register map, byte addresses
    localparam logic [31:0] PSC_REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] PSC_REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] PSC_CTRL_RESET = 32'h0000_0000;

    // control register fields
    localparam int PSC_CTRL_FOOT = 0;
    localparam int PSC_CTRL_UPPER = 1;
    localparam int PSC_CTRL_MODE1 = 2;
    localparam int PSC_CTRL_MODE2 = 3;
    localparam int PSC_CTRL_ACK = 4;

    // status register fields
    localparam int PSC_STAT_SAFE = 0;
    localparam int PSC_STAT_MUTE = 2;
    localparam int PSC_STAT_MASKED = 4;
    localparam int PSC_STAT_STOP = 5;
    localparam int PSC_STAT_STOP_CLR = 5;
endpackage : psc_pkg

// ==== pkg/psc_link_if.sv ====
// link between the guard receiver and the press safety controller
`timescale 1ns/10ps
interface psc_link_if;
    logic [1:0] field_mode;
    logic ack;
    logic foot_switch;
    logic upper_stroke_limit;
    logic [1:0] safety_switch_outputs;
    logic [1:0] mute;

    modport guard (
        input field_mode,
        input ack,
        input foot_switch,
        input upper_stroke_limit,
        output safety_switch_outputs,
        output mute
    );
    modport press (
        output field_mode,
        output ack,
        output foot_switch,
        output upper_stroke_limit,
        input safety_switch_outputs,
        input mute
    );
endinterface : psc_link_if

// ==== logic/psc_guard.sv ====
// guard receiver end: stroke sequencer driving safety and mute outputs
// Behaviour
// - field modes 0 then 1 select box bending
// - reduced stroke needs acknowledge press then release
// - top limit: all outputs off, field free
// - pinch point starts muting, mute outputs drop
// - 8 mm point: muting active, safety on
// - 6 mm point ends muting, safety drops
// - controller masks safety outputs steps five-eight
// - past 6 mm and bottom: all off
// - upward clear with top flag: mute rises
// - press returns upward without foot switch
// - after upward clearing, back to top state
// - reduced mode valid one stroke, reacknowledge each
`timescale 1ns/10ps
module psc_guard (
    input wire logic i_mclk,
    input wire logic i_reset,
    psc_link_if.guard link,
    input wire logic i_pinch_point,
    input wire logic i_point_8mm,
    input wire logic i_point_6mm,
    input wire logic i_lower_stroke_limit,
    input wire logic i_advance_clear,
    input wire logic i_field_broken,
    output psc_pkg::psc_state_t o_state,
    output logic o_dyn_muting,
    output logic o_field_interrupted,
    output logic o_reduced_armed,
    output logic o_reduced_stroke
);
    import psc_pkg::*;

    // whole sequencer state in one register, so reset and update stay in step
    typedef struct packed {
        psc_state_t state;
        logic [1:0] safe;
        logic [1:0] mute;
        logic dyn;
        logic field_int;
        logic ack_held;
        logic armed;
        logic reduced;
    } psc_guard_t;

    psc_guard_t r;
    psc_guard_t next_r;
    logic reduced_sel;
    logic start_ok;
    logic ack_done;
    logic [1:0] field_pair;

    // any mode other than standard blanks segments and needs acknowledging
    function automatic logic psc_is_reduced(input logic [1:0] mode);
        psc_is_reduced = (mode != PSC_MODE_STANDARD);
    endfunction : psc_is_reduced

    // both channels of an output pair always move together
    function automatic logic [1:0] psc_pair(input logic on);
        psc_pair = on ? 2'h3 : 2'h0;
    endfunction : psc_pair

    // a stroke starts only with the foot down and the top flag low
    function automatic logic psc_can_start(input logic foot, input logic upper,
        input logic reduced, input logic armed);
        psc_can_start = foot && !upper && (!reduced || armed);
    endfunction : psc_can_start

    // the button counts on its release, so a held button arms nothing
    function automatic logic psc_ack_done(input logic held, input logic pressed);
        psc_ack_done = held && !pressed;
    endfunction : psc_ack_done

    always_comb begin
        next_r = r;
        reduced_sel = psc_is_reduced(link.field_mode);
        start_ok = psc_can_start(link.foot_switch, link.upper_stroke_limit,
            reduced_sel, r.armed);
        ack_done = psc_ack_done(r.ack_held, link.ack);
        field_pair = psc_pair(!i_field_broken);
        // press then release arms one reduced stroke
        next_r.ack_held = link.ack;
        case (r.state)
            PSC_TOP: begin
                next_r.safe = 2'h0;
                next_r.mute = 2'h0;
                next_r.dyn = 1'b0;
                next_r.field_int = 1'b0;
                next_r.reduced = 1'b0;
                if (start_ok) begin
                    next_r.state = PSC_DOWN;
                    next_r.reduced = reduced_sel;
                    next_r.safe = 2'h3;
                    next_r.mute = 2'h3;
                    // a reduced stroke spends its acknowledgement as it starts
                    if (reduced_sel) begin
                        next_r.armed = 1'b0;
                    end
                end
            end
            PSC_DOWN: begin
                // interruption before muting drops the safety outputs at once
                next_r.field_int = i_field_broken;
                next_r.safe = field_pair;
                next_r.mute = 2'h3;
                next_r.dyn = 1'b0;
                if (i_pinch_point && !i_field_broken) begin
                    next_r.state = PSC_MUTE;
                    next_r.mute = 2'h0;
                    next_r.dyn = 1'b1;
                end
            end
            PSC_MUTE, PSC_MUTE8: begin
                // the field is blanked while muting, so a break here is expected
                next_r.safe = 2'h3;
                next_r.mute = 2'h0;
                next_r.dyn = 1'b1;
                next_r.field_int = 1'b0;
                if (i_point_6mm) begin
                    next_r.state = PSC_PAST6;
                    next_r.dyn = 1'b0;
                    next_r.field_int = 1'b1;
                    next_r.safe = 2'h0;
                end else if (i_point_8mm) begin
                    next_r.state = PSC_MUTE8;
                    next_r.safe = 2'h3;
                    next_r.mute = 2'h0;
                    next_r.field_int = 1'b0;
                end
            end
            PSC_PAST6: begin
                // a drop past 6 mm holds through the bottom until upward clearing
                next_r.safe = 2'h0;
                next_r.mute = 2'h0;
                next_r.dyn = 1'b0;
                next_r.field_int = 1'b1;
                if (i_lower_stroke_limit) begin
                    next_r.state = PSC_BOTTOM;
                end
            end
            PSC_BOTTOM: begin
                next_r.safe = 2'h0;
                next_r.mute = 2'h0;
                next_r.dyn = 1'b0;
                next_r.field_int = 1'b1;
                // foot switch is not looked at for the move from bottom into the up state
                if (i_advance_clear && link.upper_stroke_limit) begin
                    next_r.state = PSC_UP;
                    next_r.mute = 2'h3;
                    next_r.field_int = i_field_broken;
                    next_r.safe = field_pair;
                end
            end
            PSC_UP: begin
                next_r.field_int = i_field_broken;
                next_r.safe = field_pair;
                next_r.mute = 2'h3;
                next_r.dyn = 1'b0;
                // the stroke ends once the operator has let go of the foot switch
                if (!link.foot_switch) begin
                    next_r.state = PSC_TOP;
                    next_r.safe = 2'h0;
                    next_r.mute = 2'h0;
                    next_r.field_int = 1'b0;
                    next_r.reduced = 1'b0;
                end
            end
            default: begin
                // unused codes fall back to the safe top state
                next_r.state = PSC_TOP;
                next_r.safe = 2'h0;
                next_r.mute = 2'h0;
                next_r.dyn = 1'b0;
                next_r.field_int = 1'b0;
                next_r.reduced = 1'b0;
            end
        endcase
        // a release in the cycle that spends the arm still arms the next stroke
        if (ack_done) begin
            next_r.armed = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            r.state <= PSC_TOP;
            r.safe <= 2'h0;
            r.mute <= 2'h0;
            r.dyn <= 1'b0;
            r.field_int <= 1'b0;
            r.ack_held <= 1'b0;
            r.armed <= 1'b0;
            r.reduced <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // link outputs straight from the register, so no decode glitch reaches the press
    assign link.safety_switch_outputs = r.safe;
    assign link.mute = r.mute;
    assign o_state = r.state;
    assign o_dyn_muting = r.dyn;
    assign o_field_interrupted = r.field_int;
    assign o_reduced_armed = r.armed;
    assign o_reduced_stroke = r.reduced;
endmodule : psc_guard

// ==== logic/psc_press.sv ====
// press controller end: apb registers, link drive and safety masking
`timescale 1ns/10ps
module psc_press (
    input wire logic i_mclk,
    input wire logic i_reset,
    psc_link_if.press link,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_stop
);
    import psc_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic masked;
        logic stop;
        logic [1:0] safe_d;
        logic [1:0] mute_d;
    } psc_press_t;

    psc_press_t r;
    psc_press_t next_r;
    logic access;
    logic complete;
    logic hit;
    logic safe_fall;

    function automatic logic psc_fell(input logic [1:0] prev, input logic [1:0] now);
        psc_fell = (prev != 2'h0) && (now == 2'h0);
    endfunction : psc_fell

    always_comb begin
        next_r = r;
        next_r.safe_d = link.safety_switch_outputs;
        next_r.mute_d = link.mute;
        access = i_psel && i_penable && !r.pready;
        complete = i_psel && i_penable && r.pready;
        hit = (i_paddr == PSC_REG_CTRL) || (i_paddr == PSC_REG_STATUS);
        safe_fall = psc_fell(r.safe_d, link.safety_switch_outputs);
        // mask opens when muting begins so the 6 mm drop is expected
        if (psc_fell(r.mute_d, link.mute) && link.safety_switch_outputs != 2'h0) begin
            next_r.masked = 1'b1;
        end else if (r.mute_d == 2'h0 && link.mute != 2'h0) begin
            next_r.masked = 1'b0;
        end
        next_r.pready = access;
        next_r.pslverr = access && !hit;
        next_r.prdata = 32'h0;
        if (access && !i_pwrite && i_paddr == PSC_REG_CTRL) begin
            next_r.prdata = r.ctrl;
        end else if (access && !i_pwrite && i_paddr == PSC_REG_STATUS) begin
            next_r.prdata[PSC_STAT_SAFE +: 2] = link.safety_switch_outputs;
            next_r.prdata[PSC_STAT_MUTE +: 2] = link.mute;
            next_r.prdata[PSC_STAT_MASKED] = r.masked;
            next_r.prdata[PSC_STAT_STOP] = r.stop;
        end
        // writes land on the edge that sees pready, where the master ends the transfer
        if (complete && i_pwrite && i_paddr == PSC_REG_CTRL) begin
            next_r.ctrl = {27'h0, i_pwdata[4:0]};
        end
        if (complete && i_pwrite && i_paddr == PSC_REG_STATUS && i_pwdata[PSC_STAT_STOP_CLR]) begin
            next_r.stop = 1'b0;
        end
        // unmasked drop while the stroke runs stops the press; set wins over clear
        if (safe_fall && !r.masked && r.ctrl[PSC_CTRL_FOOT]) begin
            next_r.stop = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            r <= '0;
            r.ctrl <= PSC_CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign link.foot_switch = r.ctrl[PSC_CTRL_FOOT];
    assign link.upper_stroke_limit = r.ctrl[PSC_CTRL_UPPER];
    // select box bending as mode1 0, mode2 1
    assign link.field_mode = {r.ctrl[PSC_CTRL_MODE2], r.ctrl[PSC_CTRL_MODE1]};
    assign link.ack = r.ctrl[PSC_CTRL_ACK];
    assign o_prdata = r.prdata;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_stop = r.stop;
endmodule : psc_press

// ==== bench/psc_link_assertions.sv ====
// link checker for the press stroke cycle sequencer
`timescale 1ns/10ps
module psc_link_assertions (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [1:0] field_mode,
    input wire logic ack,
    input wire logic foot_switch,
    input wire logic upper_stroke_limit,
    input wire logic [1:0] safety_switch_outputs,
    input wire logic [1:0] mute
);
    import psc_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    wire [1:0] s = safety_switch_outputs;
    wire [1:0] m = mute;
    sequence s_top;
        !foot_switch && upper_stroke_limit;
    endsequence
    sequence s_start;
        $rose(foot_switch) && !upper_stroke_limit && field_mode == PSC_MODE_STANDARD;
    endsequence
    property p_top_idle;
        s_top [*2] |-> s == 2'h0 && m == 2'h0;
    endproperty
    property p_start;
        s_start ##0 s == 2'h0 |=> s == 2'h3 && m == 2'h3;
    endproperty
    property p_mute_rise;
        $rose(m[0]) && upper_stroke_limit |-> $past(upper_stroke_limit);
    endproperty
    property p_up_hold;
        m == 2'h3 && upper_stroke_limit && foot_switch |=> m == 2'h3;
    endproperty
    property p_pair;
        s[0] == s[1] && m[0] == m[1];
    endproperty
    // after the 6 mm drop both output pairs must stay off for the next two cycles
    property p_past6;
        $fell(s[0]) && m == 2'h0 |=> (s == 2'h0 && m == 2'h0) [*2];
    endproperty
    property p_muted;
        m == 2'h0 && s == 2'h3 |=> m == 2'h0;
    endproperty
    property p_idle;
        s == 2'h0 && m == 2'h0 && !foot_switch && !upper_stroke_limit |=> s == 2'h0 && m == 2'h0;
    endproperty
    a_top_idle: assert property (p_top_idle) else $error("outputs on at top");
    a_start: assert property (p_start) else $error("no start of stroke");
    a_mute_rise: assert property (p_mute_rise) else $error("early mute rise");
    a_up_hold: assert property (p_up_hold) else $error("mute lost on return");
    a_pair: assert property (p_pair) else $error("output pair differs");
    a_past6: assert property (p_past6) else $error("output back past 6 mm");
    a_muted: assert property (p_muted) else $error("mute rose while muting");
    a_idle: assert property (p_idle) else $error("start without foot");
endmodule : psc_link_assertions

// ==== bench/tb_press_stroke_cycle_sequencer.sv ====
// self-checking bench joining both ends of the sequencer
`timescale 1ns/10ps
module tb_press_stroke_cycle_sequencer;
    import psc_pkg::*;
    logic i_mclk = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0, perr;
    logic [31:0] padr = 0, pwd = 0, prd, rdat;
    logic rdy, err, stp, dm, fi, arm, red;
    logic [5:0] sn = 0;
    psc_state_t st;
    int bad_count = 0, check_count = 0, cyc = 0;
    psc_link_if link ();
    psc_guard i_psc_guard (.i_mclk(i_mclk), .i_reset(i_reset), .link(link),
        .i_pinch_point(sn[0]), .i_point_8mm(sn[1]), .i_point_6mm(sn[2]),
        .i_lower_stroke_limit(sn[3]), .i_advance_clear(sn[4]), .i_field_broken(sn[5]),
        .o_state(st), .o_dyn_muting(dm), .o_field_interrupted(fi), .o_reduced_armed(arm),
        .o_reduced_stroke(red));
    psc_press i_psc_press (.i_mclk(i_mclk), .i_reset(i_reset), .link(link), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(err), .o_stop(stp));
    psc_link_assertions i_psc_link_assertions (.i_mclk(i_mclk), .i_reset(i_reset),
        .field_mode(link.field_mode), .ack(link.ack), .foot_switch(link.foot_switch),
        .upper_stroke_limit(link.upper_stroke_limit),
        .safety_switch_outputs(link.safety_switch_outputs), .mute(link.mute));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // whole run is under two hundred cycles
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge i_mclk);
        pen <= 1;
        @(posedge i_mclk);
        while (rdy !== 1'b1) @(posedge i_mclk);
        rdat = prd;
        perr = err;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rdat, e);
    endtask : rd
    // sensing events are one-cycle pulses; the state shows one edge later and is checked on the edge after
    task automatic go(input logic [5:0] v, input logic [8:0] e);
        @(posedge i_mclk);
        sn <= v;
        @(posedge i_mclk);
        sn <= 6'h0;
        @(posedge i_mclk);
        #1;
        chk(32'({st, link.safety_switch_outputs, link.mute, dm, fi}), 32'(e));
    endtask : go
    task automatic finish_stroke(input logic [31:0] base);
        go(6'h8, {PSC_BOTTOM, 4'h0, 2'h1});
        apb(1, PSC_REG_CTRL, base | 32'h3);
        go(6'h10, {PSC_UP, 4'hf, 2'h0});
        apb(1, PSC_REG_CTRL, base | 32'h2);
        go(6'h0, {PSC_TOP, 4'h0, 2'h0});
    endtask : finish_stroke
    initial begin
        repeat (20) @(posedge i_mclk);
        i_reset <= 0;
        rd(PSC_REG_CTRL, PSC_CTRL_RESET);
        rd(PSC_REG_STATUS, 32'h0);
        rd(32'h8, 32'h0);
        chk(32'(perr), 32'h1);
        apb(1, PSC_REG_CTRL, 32'h1);
        go(6'h0, {PSC_DOWN, 4'hf, 2'h0});
        go(6'h1, {PSC_MUTE, 4'hc, 2'h2});
        go(6'h2, {PSC_MUTE8, 4'hc, 2'h2});
        go(6'h4, {PSC_PAST6, 4'h0, 2'h1});
        rd(PSC_REG_STATUS, 32'h10);
        finish_stroke(32'h0);
        rd(PSC_REG_STATUS, 32'h0);
        apb(1, PSC_REG_CTRL, 32'h9);
        go(6'h0, {PSC_TOP, 4'h0, 2'h0});
        apb(1, PSC_REG_CTRL, 32'hffff_fff8);
        rd(PSC_REG_CTRL, 32'h18);
        apb(1, PSC_REG_CTRL, 32'h8);
        go(6'h0, {PSC_TOP, 4'h0, 2'h0});
        chk(32'(arm), 32'h1);
        apb(1, PSC_REG_CTRL, 32'h9);
        go(6'h0, {PSC_DOWN, 4'hf, 2'h0});
        chk(32'(red), 32'h1);
        go(6'h1, {PSC_MUTE, 4'hc, 2'h2});
        go(6'h4, {PSC_PAST6, 4'h0, 2'h1});
        finish_stroke(32'h8);
        apb(1, PSC_REG_CTRL, 32'h9);
        go(6'h0, {PSC_TOP, 4'h0, 2'h0});
        apb(1, PSC_REG_CTRL, 32'h1);
        go(6'h0, {PSC_DOWN, 4'hf, 2'h0});
        @(posedge i_mclk);
        sn <= 6'h20;
        repeat (3) @(posedge i_mclk);
        #1;
        chk(32'(stp), 32'h1);
        apb(1, PSC_REG_STATUS, 32'h20);
        @(posedge i_mclk);
        #1;
        chk(32'(stp), 32'h0);
        end_of_test();
    end
endmodule : tb_press_stroke_cycle_sequencer
